// *** src/serial_port.sv ***
// Overview of operation
// - Full-duplex byte exchange on one clock.
// - Most significant bit first, both roles.
// - Received byte replaces sent; one done flag.
// - Slave follows clock up to core/4.
// - Low two rate-select bits pick master bit rate.
// - Master drives its own serial clock.
// - Master needs select high, else bits drop.
// - Master drives MOSI, samples MISO.
// - Master transmit write starts a transfer.
// - Byte loaded in parallel, then shifted out.
// - Done sets flag, interrupts if enabled.
// - Last clock copies received byte to buffer.
// - Flag clears: status access, then data read.
// - Writes ignored while flag set, unread status.
// - Slave takes clock from pin only.
// - Slave ignores rate-select bits.
// - Slave entered: master clear, enable set.
// - Slave samples MOSI, drives MISO.
// - Idle level sets resting clock level.
// - Phase picks first or second capture edge.
// - Select low on master: fault, drop out.
// - Write during transfer sets collision flag.
module serial_port
   import serial_port_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Processor side
   input  wire logic                ctrl_write,
   input  wire serial_control_reg_t ctrl_in,
   output serial_control_reg_t      ctrl_out,
   input  wire logic                status_access,
   output serial_status_reg_t       status_out,
   input  wire logic                tx_write,
   input  wire logic [7:0]          tx_data,
   input  wire logic                rx_read,
   output logic [7:0]               rx_data,
   output logic                     transfer_irq,
   // Serial pins
   input  wire logic                sck_in,
   output logic                     sck_out,
   output logic                     sck_oe,
   input  wire logic                mosi_in,
   output logic                     mosi_out,
   output logic                     mosi_oe,
   input  wire logic                miso_in,
   output logic                     miso_out,
   output logic                     miso_oe,
   input  wire logic                ss_n_in
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic       sck_d;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 4'hF;
         sync2 <= 4'hF;
      end else begin
         sync1 <= {ss_n_in, sck_in, mosi_in, miso_in};
         sync2 <= sync1;
      end
   end

   logic ss_low;
   logic sck_s;
   logic mosi_s;
   logic miso_s;

   assign ss_low = !sync2[3];
   assign sck_s  = sync2[2];
   assign mosi_s = sync2[1];
   assign miso_s = sync2[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
      end
   end

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   serial_control_reg_t ctrl;
   xfer_state_t         state;
   logic [7:0]          shreg;
   logic [7:0]          rx_buf;
   logic [2:0]          bit_cnt;
   logic                sample_bit;
   logic                out_bit;
   logic                sck_level;
   logic                done_flag;
   logic                done_armed;
   logic                coll_flag;
   logic                coll_armed;
   logic                fault_flag;
   logic                fault_armed;
   logic                tick;

   // Shift one bit in at the bottom, MSB leaves first
   function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d);
      shift_in = {b[6:0], d};
   endfunction

   // ---------------------------------------------------------------
   // Edge decode
   // ---------------------------------------------------------------
   logic master_on;
   logic slave_on;
   logic slave_sel;
   logic fault;
   logic lead_ev;
   logic trail_ev;
   logic in_bit;
   logic busy;
   logic tx_blocked;
   logic tx_accept;
   logic done;

   assign master_on = ctrl.port_enable && ctrl.master_select;
   assign slave_on  = ctrl.port_enable && !ctrl.master_select;
   assign slave_sel = slave_on && ss_low;
   assign fault     = master_on && ss_low;

   always_comb begin
      lead_ev  = 1'b0;
      trail_ev = 1'b0;
      if (state == st_master && tick) begin
         lead_ev  = (sck_level == ctrl.clock_idle_level);
         trail_ev = (sck_level != ctrl.clock_idle_level);
      end else if (slave_sel && sck_s != sck_d) begin
         lead_ev  = (sck_s != ctrl.clock_idle_level);
         trail_ev = (sck_s == ctrl.clock_idle_level);
      end
   end

   assign in_bit     = ctrl.master_select ? miso_s : mosi_s;
   assign busy       = state != st_idle || (slave_sel && !ctrl.clock_sample_phase);
   assign tx_blocked = done_flag && !done_armed;
   assign tx_accept  = tx_write && ctrl.port_enable && !busy && !tx_blocked && !fault;
   assign done       = trail_ev && bit_cnt == LAST_BIT;

   // ---------------------------------------------------------------
   // Transfer sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_idle;
      end else if (fault || !ctrl.port_enable) begin
         state <= st_idle;
      end else if (state == st_slave && !ss_low) begin
         state <= st_idle;
      end else if (done) begin
         state <= st_idle;
      end else if (tx_accept && ctrl.master_select) begin
         state <= st_master;
      end else if (state == st_idle && slave_sel && (lead_ev || trail_ev)) begin
         state <= st_slave;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= '0;
      end else if (state == st_idle && !(slave_sel && (lead_ev || trail_ev))) begin
         bit_cnt <= '0;
      end else if (trail_ev) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // Master clock level; rests at idle level between bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_level <= 1'b0;
      end else if (state != st_master) begin
         sck_level <= ctrl.clock_idle_level;
      end else if (tick) begin
         sck_level <= !sck_level;
      end
   end

   // ---------------------------------------------------------------
   // Shift path
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg      <= DATA_RESET;
         out_bit    <= 1'b0;
         sample_bit <= 1'b0;
      end else if (tx_accept) begin
         shreg   <= tx_data;
         out_bit <= tx_data[7];
      end else if (lead_ev) begin
         if (!ctrl.clock_sample_phase) begin
            sample_bit <= in_bit;
         end else begin
            out_bit <= shreg[7];
         end
      end else if (trail_ev) begin
         if (!ctrl.clock_sample_phase) begin
            shreg   <= shift_in(shreg, sample_bit);
            out_bit <= shreg[6];
         end else begin
            shreg <= shift_in(shreg, in_bit);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf <= DATA_RESET;
      end else if (done) begin
         rx_buf <= !ctrl.clock_sample_phase ? shift_in(shreg, sample_bit)
                                            : shift_in(shreg, in_bit);
      end
   end

   // ---------------------------------------------------------------
   // Status flags; a set wins over a clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_flag  <= 1'b0;
         done_armed <= 1'b0;
      end else if (done) begin
         done_flag  <= 1'b1;
         done_armed <= 1'b0;
      end else if (done_flag && done_armed && rx_read) begin
         done_flag  <= 1'b0;
         done_armed <= 1'b0;
      end else if (done_flag && status_access) begin
         done_armed <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coll_flag  <= 1'b0;
         coll_armed <= 1'b0;
      end else if (tx_write && ctrl.port_enable && busy) begin
         coll_flag  <= 1'b1;
         coll_armed <= 1'b0;
      end else if (coll_flag && coll_armed && rx_read) begin
         coll_flag  <= 1'b0;
         coll_armed <= 1'b0;
      end else if (coll_flag && status_access) begin
         coll_armed <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_flag  <= 1'b0;
         fault_armed <= 1'b0;
      end else if (fault) begin
         fault_flag  <= 1'b1;
         fault_armed <= 1'b0;
      end else if (fault_flag && fault_armed && ctrl_write) begin
         fault_flag  <= 1'b0;
         fault_armed <= 1'b0;
      end else if (fault_flag && status_access) begin
         fault_armed <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (fault) begin
         ctrl.port_enable   <= 1'b0;
         ctrl.master_select <= 1'b0;
      end else if (ctrl_write) begin
         ctrl <= ctrl_in;
         if (fault_flag && !fault_armed) begin
            ctrl.port_enable   <= 1'b0;
            ctrl.master_select <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_oe       <= 1'b0;
         mosi_oe      <= 1'b0;
         miso_oe      <= 1'b0;
         transfer_irq <= 1'b0;
      end else begin
         sck_oe       <= master_on;
         mosi_oe      <= master_on;
         miso_oe      <= slave_sel;
         transfer_irq <= ctrl.transfer_irq_enable && (done_flag || fault_flag);
      end
   end

   assign sck_out    = sck_level;
   assign mosi_out   = out_bit;
   assign miso_out   = out_bit;
   assign rx_data    = rx_buf;
   assign ctrl_out   = ctrl;
   assign status_out = '{done_flag, coll_flag, fault_flag};

   sck_rate_divider i_sck_rate_divider (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (state == st_master),
      .rate  ({ctrl.rate_select_2, ctrl.rate_select_1, ctrl.rate_select_0}),
      .tick  (tick)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   done_sets_flag_a: assert property (done |=> done_flag)
      else $error("completion did not set flag");
   flag_clear_seq_a: assert property ($fell(done_flag) |-> $past(done_armed)
                                      && $past(rx_read))
      else $error("flag cleared without status access and read");
   tx_inhibit_a: assert property (tx_write && tx_blocked && !busy |=> $stable(shreg))
      else $error("transmit write accepted while flag pending");
   fault_drop_a: assert property (fault |=> !ctrl.port_enable && !ctrl.master_select
                                  && fault_flag)
      else $error("mode fault did not drop master");
   collision_set_a: assert property (tx_write && ctrl.port_enable && busy |=> coll_flag
                                     && ($stable(shreg) || $past(lead_ev || trail_ev)))
      else $error("collision not flagged");
   rx_copy_a: assert property (done |=> rx_data == $past(shift_in(shreg,
                               ctrl.clock_sample_phase ? in_bit : sample_bit)))
      else $error("receive buffer not loaded");
   master_start_a: assert property (tx_accept && ctrl.master_select |=> state == st_master)
      else $error("transmit write did not start master transfer");
   idle_level_a: assert property (state == st_idle ##1 state == st_idle
                                  |-> sck_out == $past(ctrl.clock_idle_level))
      else $error("clock not resting at idle level");
   load_msb_a: assert property (tx_accept |=> mosi_out == $past(tx_data[7])
                                && shreg == $past(tx_data))
      else $error("byte not loaded with MSB out");
   irq_follow_a: assert property (done_flag && ctrl.transfer_irq_enable |=> transfer_irq)
      else $error("interrupt not raised");

   master_byte_c: cover property (state == st_master ##[1:600] done);
   slave_byte_c:  cover property (state == st_slave ##[1:600] done);
   fault_c:       cover property (fault);
   collision_c:   cover property (tx_write && busy);

endmodule

// *** src/serial_port_pkg.sv ***
package serial_port_pkg;

   // ---------------------------------------------------------------
   // Control and status carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       transfer_irq_enable;
      logic       port_enable;
      logic       master_select;
      logic       clock_idle_level;
      logic       clock_sample_phase;
      logic       rate_select_2;
      logic       rate_select_1;
      logic       rate_select_0;
   } serial_control_reg_t;

   typedef struct packed {
      logic       transfer_complete_flag;
      logic       write_collision_flag;
      logic       mode_fault_flag;
   } serial_status_reg_t;

   typedef enum logic [1:0] {
      st_idle,
      st_master,
      st_slave
   } xfer_state_t;

   // ---------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------
   localparam int unsigned        CORE_CLOCK_FREQ = 100_000_000;
   localparam int unsigned        BYTE_BITS       = 8;
   localparam int unsigned        CNT_W           = 6;
   localparam logic [2:0]         LAST_BIT        = 3'h7;
   localparam logic [CNT_W-1:0]   HALF_PERIOD_0   = 6'h04;
   localparam logic [CNT_W-1:0]   HALF_PERIOD_1   = 6'h08;
   localparam logic [CNT_W-1:0]   HALF_PERIOD_2   = 6'h10;
   localparam logic [CNT_W-1:0]   HALF_PERIOD_3   = 6'h20;
   localparam serial_control_reg_t CTRL_RESET     = '0;
   localparam logic [7:0]         DATA_RESET      = 8'h00;

endpackage

// *** src/sck_rate_divider.sv ***
module sck_rate_divider
   import serial_port_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] rate,
   // Half-period strobe
   output logic            tick
);

   logic [CNT_W-1:0] count;

   // Codes 4..7 repeat codes 0..3
   function automatic logic [CNT_W-1:0] half_period(input logic [2:0] code);
      case (code[1:0])
         2'h0:    half_period = HALF_PERIOD_0;
         2'h1:    half_period = HALF_PERIOD_1;
         2'h2:    half_period = HALF_PERIOD_2;
         default: half_period = HALF_PERIOD_3;
      endcase
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (!run) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == half_period(rate) - 6'h01) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + 6'h01;
         tick  <= 1'b0;
      end
   end

endmodule

// *** tb/spi_far_end.sv ***
module spi_far_end (
   // Mode and timing, set equal to the device by the bench
   input  wire logic dut_master,
   input  wire logic idle_level,
   input  wire logic sample_phase,
   // Resolved lines
   input  wire logic sck_line,
   input  wire logic mosi_line,
   input  wire logic miso_line,
   // Far-side drivers
   output logic      sck_drv,
   output logic      mosi_drv,
   output logic      miso_drv,
   output logic      ss_n
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] tx_sh = 8'h00;
   logic [7:0] rx_sh = 8'h00;

   initial begin
      sck_drv = 1'b0;
      mosi_drv = 1'b0;
      miso_drv = 1'b0;
      ss_n = 1'b1;
   end

   // ---------------------------------------------------------------
   // Slave role: follows the device clock
   // ---------------------------------------------------------------
   always @(sck_line) begin
      if (dut_master) begin
         if ((sck_line != idle_level) ^ sample_phase) begin
            rx_sh = {rx_sh[6:0], mosi_line};
         end else if (sample_phase) begin
            miso_drv = tx_sh[7];
            tx_sh = {tx_sh[6:0], ~tx_sh[7]};
         end else begin
            tx_sh = {tx_sh[6:0], ~tx_sh[7]};
            miso_drv = tx_sh[7];
         end
      end
   end

   task automatic load(input logic [7:0] b);
      tx_sh = b;
      miso_drv = b[7];
   endtask

   task automatic set_ss(input logic v);
      ss_n = v;
   endtask

   // ---------------------------------------------------------------
   // Master role: clock stands at idle outside the frame
   // ---------------------------------------------------------------
   task automatic xfer(input logic [7:0] b, input int half, output logic [7:0] got);
      logic [7:0] sh;
      sh = b;
      got = 8'h00;
      sck_drv = idle_level;
      // Let a changed idle level settle before select falls
      #(2 * half);
      ss_n = 1'b0;
      mosi_drv = sh[7];
      #(half);
      for (int i = 0; i < 8; i++) begin
         sck_drv = ~idle_level;
         if (sample_phase) mosi_drv = sh[7];
         else got = {got[6:0], miso_line};
         #(half);
         sck_drv = idle_level;
         if (sample_phase) got = {got[6:0], miso_line};
         sh = {sh[6:0], 1'b0};
         if (!sample_phase) mosi_drv = sh[7];
         #(half);
      end
      ss_n = 1'b1;
      mosi_drv = ~mosi_drv;
   endtask
endmodule

// *** tb/serial_port_test.sv ***
module serial_port_test
   import serial_port_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic                clk;
   logic                rst_n;
   logic                ctrl_write, status_access, tx_write, rx_read, transfer_irq;
   serial_control_reg_t ctrl_in, ctrl_out;
   serial_status_reg_t  status_out;
   logic [7:0]          tx_data, rx_data;
   logic                sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   wire logic           sck_line, mosi_line, miso_line, sck_drv, mosi_drv, miso_drv, ss_n;
   logic                far_idle, far_phase, done_prev;
   logic [7:0]          exp_q[$];
   int                  miscompares = 0;
   int                  total_checks = 0;
   logic [CNT_W-1:0]    halves [4] = '{HALF_PERIOD_0, HALF_PERIOD_1, HALF_PERIOD_2,
                                       HALF_PERIOD_3};

   assign sck_line  = sck_oe ? sck_out : sck_drv;
   assign mosi_line = mosi_oe ? mosi_out : mosi_drv;
   assign miso_line = miso_oe ? miso_out : miso_drv;

   serial_port i_serial_port (
      .clk(clk), .rst_n(rst_n), .ctrl_write(ctrl_write), .ctrl_in(ctrl_in),
      .ctrl_out(ctrl_out), .status_access(status_access), .status_out(status_out),
      .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read), .rx_data(rx_data),
      .transfer_irq(transfer_irq), .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe),
      .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_line),
      .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n));

   spi_far_end i_spi_far_end (
      .dut_master(sck_oe), .idle_level(far_idle), .sample_phase(far_phase), .sck_line(sck_line),
      .mosi_line(mosi_line), .miso_line(miso_line), .sck_drv(sck_drv),
      .mosi_drv(mosi_drv), .miso_drv(miso_drv), .ss_n(ss_n));

   always #5 clk = ~clk;

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask

   task automatic wr_ctrl(input serial_control_reg_t c);
      ctrl_in = c;
      pulse(ctrl_write);
   endtask

   task automatic wr_tx(input logic [7:0] b);
      tx_data = b;
      pulse(tx_write);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (status_out.transfer_complete_flag !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      tick(2);
   endtask

   // ---------------------------------------------------------------
   // Received-byte watcher
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      done_prev <= status_out.transfer_complete_flag;
      if (status_out.transfer_complete_flag === 1'b1 && done_prev !== 1'b1) begin
         if (exp_q.size() == 0) check(rx_data, ~rx_data);
         else check(rx_data, exp_q.pop_front());
      end
   end

   task automatic master_run(input logic [2:0] code);
      serial_control_reg_t c;
      logic [7:0]          b;
      logic [7:0]          s;
      int                  n;
      b = 8'($urandom);
      s = 8'($urandom);
      c = serial_control_reg_t'({code[0], 2'h3, code[1], code[0] ^ code[2], code});
      far_idle = c.clock_idle_level;
      far_phase = c.clock_sample_phase;
      wr_ctrl(c);
      tick(3);
      check(8'({sck_out, sck_oe, mosi_oe, miso_oe}), 8'({c.clock_idle_level, 3'h6}));
      i_spi_far_end.load(s);
      exp_q.push_back(s);
      wr_tx(b);
      n = 0;
      while (sck_out === c.clock_idle_level && n < 100) begin
         tick(1);
         n++;
      end
      n = 0;
      while (sck_out !== c.clock_idle_level && n < 100) begin
         tick(1);
         n++;
      end
      check(8'(n), 8'(halves[code[1:0]]));
      if (code == 3'h5) begin
         wr_tx(~b);
         tick(1);
         check(8'({status_out.write_collision_flag, transfer_irq}), 8'h02);
      end
      wait_done();
      check(8'(transfer_irq), 8'(c.transfer_irq_enable));
      check(i_spi_far_end.rx_sh, b);
      wr_tx(8'h5A);
      tick(80);
      check(8'({sck_out, status_out.write_collision_flag}),
            8'({c.clock_idle_level, code == 3'h5}));
      pulse(status_access);
      tick(1);
      check(8'(status_out.transfer_complete_flag), 8'h01);
      pulse(rx_read);
      tick(1);
      check(8'(status_out), 8'h00);
      $display("Done: master code %0d", code);
   endtask

   task automatic mode_fault_run();
      wr_ctrl(serial_control_reg_t'(8'hE0));
      tick(3);
      i_spi_far_end.set_ss(1'b0);
      tick(8);
      check(8'(status_out), 8'h01);
      check(8'({ctrl_out.port_enable, ctrl_out.master_select, transfer_irq}), 8'h01);
      i_spi_far_end.set_ss(1'b1);
      wr_ctrl(serial_control_reg_t'(8'hE0));
      tick(2);
      check(8'({ctrl_out.port_enable, ctrl_out.master_select}), 8'h00);
      pulse(status_access);
      wr_ctrl(serial_control_reg_t'(8'hE0));
      tick(2);
      check(8'(status_out), 8'h00);
      check(8'(ctrl_out), 8'hE0);
      $display("Done: mode fault");
   endtask

   task automatic slave_run(input logic [1:0] mode, input int half);
      logic [7:0] b;
      logic [7:0] s;
      logic [7:0] got;
      b = 8'($urandom);
      s = 8'($urandom);
      far_idle = mode[1];
      far_phase = mode[0];
      wr_ctrl(serial_control_reg_t'({3'h2, mode, 3'($urandom)}));
      wr_tx(b);
      tick(2);
      check(8'({sck_oe, mosi_oe}), 8'h00);
      exp_q.push_back(s);
      i_spi_far_end.xfer(s, half, got);
      tick(1);
      wait_done();
      if (half > 20) check(got, b);
      pulse(status_access);
      pulse(rx_read);
      tick(1);
      check(8'(status_out), 8'h00);
      $display("Done: slave mode %0d half %0d ns", mode, half);
   endtask

   initial begin
      #200_000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ctrl_write = 1'b0;
      ctrl_in = '0;
      status_access = 1'b0;
      tx_write = 1'b0;
      tx_data = 8'h00;
      rx_read = 1'b0;
      far_idle = 1'b0;
      far_phase = 1'b0;
      void'($urandom(32));
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      tick(1);
      check(8'(ctrl_out), 8'(CTRL_RESET));
      check(rx_data, DATA_RESET);
      check(8'({status_out, sck_oe, mosi_oe, miso_oe, transfer_irq}), 8'h00);
      $display("Done: reset");
      for (int k = 0; k < 8; k++) master_run(3'(k));
      mode_fault_run();
      for (int k = 0; k < 4; k++) slave_run(2'(k), 80);
      for (int k = 0; k < 4; k++) slave_run(2'(k), 20);
      report_and_stop();
   end
endmodule
